// ### btme_defines.svh
// Purpose: Constants for the branch, timer and misc execution unit.
// Assumes: 10-bit instruction words, byte addressed APB map.
// Notes:   Opcodes are full 10-bit words unless named as a prefix.
`ifndef BTME_DEFINES_SVH
`define BTME_DEFINES_SVH
`define BTME_OP_IDLE   10'h000
`define BTME_OP_JMP    10'h111
`define BTME_OP_JC     10'h191
`define BTME_OP_JNC    10'h1B1
`define BTME_OP_JF     10'h1D1
`define BTME_OP_JNF    10'h1F1
`define BTME_OP_CALL   10'h0D2
`define BTME_OP_RET    10'h112
`define BTME_OP_RDT0   10'h3DF
`define BTME_OP_RDT1   10'h3FF
`define BTME_OP_WRT0   10'h09F
`define BTME_OP_WRT1   10'h0BF
`define BTME_OP_LDTI   10'h0DF
`define BTME_OP_LDTR   10'h0FF
`define BTME_OP_HALT   10'h051
`define BTME_OP_STTSI  10'h071
`define BTME_OP_CARRY_IF_ALL_ONES   10'h353
`define BTME_PF_STTSR  6'h06
`define BTME_PF_LDPAIR 6'h0E
`define BTME_A_INSN    12'h000
`define BTME_A_OPND    12'h004
`define BTME_A_EXEC    12'h008
`define BTME_A_PC      12'h00C
`define BTME_A_ACC     12'h010
`define BTME_A_TMR     12'h014
`define BTME_A_CFG     12'h018
`define BTME_A_STK     12'h01C
`define BTME_A_LOBANK  6'h01
`define BTME_A_HIBANK  6'h02
`define BTME_ALL_ONES  4'hF
`define BTME_DIV_FAST  5'h08
`define BTME_DIV_SLOW  5'h10
`endif

// ### btme_pkg.sv
// Purpose: Types for the branch, timer and misc execution unit.
// Assumes: Constants live in btme_defines.svh.
// Notes:   Only the sequencer state needs a shared type.
package btme_pkg;
   typedef enum logic [0:0] {
      BTME_IDLE  = 1'b0,
      BTME_CALL2 = 1'b1
   } btme_state_e;
endpackage : btme_pkg

// ### btme_exec.sv
// Purpose: Executes branch, call, timer, standby, status test, carry ops.
// Assumes: Table data returns combinationally for o_tbl_addr.
// Notes:   Software feeds words and starts each op over APB.
`timescale 1ns/1ps
`include "btme_defines.svh"
module btme_exec #(
   parameter int SP_W = 1
) (
   // Clock and reset.
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   // APB slave.
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // Program table port.
   output logic [9:0]       o_tbl_addr,
   input  wire logic [9:0]  i_tbl_data,
   // Status inputs.
   input  wire logic        i_sense_input_zero,
   input  wire logic        i_sense_led_pin,
   input  wire logic [7:0]  i_key_bidir_lines,
   input  wire logic [3:0]  i_key_input_lines,
   // Core status outputs.
   output logic             o_int_reset,
   output logic             o_standby,
   output logic             o_timer_done
);
   btme_pkg::btme_state_e state_q, state_d;
   logic [9:0]  insn_q, opnd_q, pc_q, pc_d, asr_q, asr_d, tmr_q, tmr_d;
   logic [SP_W-1:0] sp_q, sp_d;
   logic [3:0]  acc_q, acc_d, rel_q, rel_d;
   logic        carry_q, carry_d, match_q, match_d;
   logic        stby_q, stby_d, bad_q, bad_d, irst_d;
   logic [1:0]  page_q;
   logic        div16_q, start_q;
   logic [3:0]  lo_bank_q [16];
   logic [3:0]  hi_bank_q [16];
   logic [9:0]  tcnt_q;
   logic [3:0]  pre_q;
   logic        trun_q, tdone_q;

   // APB decode; a write lands only at the access edge with pready high.
   wire wr_en  = i_psel & i_penable & i_pwrite & o_pready;
   wire setup  = i_psel & ~i_penable;
   wire is_lo  = i_paddr[11:6] == `BTME_A_LOBANK;
   wire is_hi  = i_paddr[11:6] == `BTME_A_HIBANK;
   wire [3:0] bidx = i_paddr[5:2];
   wire go     = start_q & (state_q == btme_pkg::BTME_IDLE);

   // Operand fields.
   wire [9:0] tgt  = {opnd_q[9], opnd_q[4], opnd_q[8:5], opnd_q[3:0]};
   wire [9:0] tval = {opnd_q[8:5], opnd_q[3:0], opnd_q[9], opnd_q[4]};
   wire [9:0] tbl_tval = {i_tbl_data[8:5], i_tbl_data[3:0],
                          i_tbl_data[9], i_tbl_data[4]};
   wire [3:0] ridx = insn_q[3:0];
   wire [3:0] stat = {tdone_q, (|i_key_bidir_lines) | (|i_key_input_lines),
                      i_sense_led_pin, i_sense_input_zero};
   wire [9:0] pc1  = pc_q + 10'h001;
   wire [9:0] pc2  = pc_q + 10'h002;
   wire       sp_full  = &sp_q;
   wire       sp_empty = ~|sp_q;
   wire       is_ldpair = insn_q[9:4] == `BTME_PF_LDPAIR;
   wire       pair_wr  = go & is_ldpair & (ridx != 4'h0);
   // Prescaler end count; the cast drops the unused top bit on purpose.
   wire [3:0] pre_top = div16_q ? 4'(`BTME_DIV_SLOW - 5'h01)
                                : 4'(`BTME_DIV_FAST - 5'h01);

   // Execution next state; the default holds every register but clears the internal reset pulse.
   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      asr_d   = asr_q;
      sp_d    = sp_q;
      tmr_d   = tmr_q;
      acc_d   = acc_q;
      carry_d = carry_q;
      match_d = match_q;
      stby_d  = stby_q;
      rel_d   = rel_q;
      bad_d   = bad_q;
      irst_d  = 1'b0;
      if (state_q == btme_pkg::BTME_CALL2) begin
         pc_d    = tgt;
         state_d = btme_pkg::BTME_IDLE;
      end else if (go) begin
         pc_d  = pc1;
         bad_d = 1'b0;
         if (insn_q == `BTME_OP_IDLE) begin
            pc_d = pc1;
         end else if (insn_q == `BTME_OP_JMP) begin
            pc_d = tgt;
         end else if (insn_q == `BTME_OP_JC) begin
            pc_d = carry_q ? tgt : pc2;
         end else if (insn_q == `BTME_OP_JNC) begin
            pc_d = !carry_q ? tgt : pc2;
         end else if (insn_q == `BTME_OP_JF) begin
            pc_d = match_q ? tgt : pc2;
         end else if (insn_q == `BTME_OP_JNF) begin
            pc_d = !match_q ? tgt : pc2;
         end else if (insn_q == `BTME_OP_CALL) begin
            if (sp_full) begin
               irst_d = 1'b1;
            end else begin
               sp_d    = sp_q + SP_W'(1);
               asr_d   = pc2;
               state_d = btme_pkg::BTME_CALL2;
            end
         end else if (insn_q == `BTME_OP_RET) begin
            if (sp_empty) begin
               irst_d = 1'b1;
            end else begin
               pc_d = asr_q;
               sp_d = sp_q - SP_W'(1);
            end
         end else if (insn_q == `BTME_OP_RDT1) begin
            acc_d   = tmr_q[9:6];
            carry_d = 1'b0;
         end else if (insn_q == `BTME_OP_RDT0) begin
            acc_d   = tmr_q[5:2];
            carry_d = 1'b0;
         end else if (insn_q == `BTME_OP_WRT1) begin
            tmr_d = {acc_q, tmr_q[5:2], 1'b0, tmr_q[0]};
         end else if (insn_q == `BTME_OP_WRT0) begin
            tmr_d = {tmr_q[9:6], acc_q, tmr_q[1], 1'b0};
         end else if (insn_q == `BTME_OP_LDTI) begin
            tmr_d = tval;
            pc_d  = pc2;
         end else if (insn_q == `BTME_OP_LDTR) begin
            tmr_d = tbl_tval;
         end else if (insn_q == `BTME_OP_HALT) begin
            stby_d = 1'b1;
            rel_d  = opnd_q[3:0];
            pc_d   = pc2;
         end else if (insn_q == `BTME_OP_STTSI) begin
            match_d = |(stat & opnd_q[3:0]);
            pc_d    = pc2;
         end else if (insn_q[9:4] == `BTME_PF_STTSR) begin
            match_d = |(stat & lo_bank_q[ridx]);
         end else if (insn_q == `BTME_OP_CARRY_IF_ALL_ONES) begin
            carry_d = acc_q == `BTME_ALL_ONES;
         end else if (is_ldpair) begin
            pc_d = pc1;
         end else begin
            bad_d = 1'b1;
         end
      end
      // Software side writes lose to a running op in the same cycle.
      if (wr_en && !go && state_q == btme_pkg::BTME_IDLE) begin
         if (i_paddr == `BTME_A_PC) begin
            pc_d = i_pwdata[9:0];
         end else if (i_paddr == `BTME_A_ACC) begin
            acc_d   = i_pwdata[3:0];
            carry_d = i_pwdata[4];
            match_d = i_pwdata[5];
         end else if (i_paddr == `BTME_A_EXEC && i_pwdata[1]) begin
            stby_d = 1'b0;
         end
      end
      // Internal reset returns the core to its start point.
      if (irst_d) begin
         pc_d    = 10'h000;
         sp_d    = '0;
         carry_d = 1'b0;
         match_d = 1'b0;
         stby_d  = 1'b0;
         state_d = btme_pkg::BTME_IDLE;
      end
   end

   // Core state registers.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= btme_pkg::BTME_IDLE;
         pc_q    <= 10'h000;
         asr_q   <= 10'h000;
         sp_q    <= '0;
         tmr_q   <= 10'h000;
         acc_q   <= 4'h0;
         carry_q <= 1'b0;
         match_q <= 1'b0;
         stby_q  <= 1'b0;
         rel_q   <= 4'h0;
         bad_q   <= 1'b0;
         o_int_reset <= 1'b0;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         asr_q   <= asr_d;
         sp_q    <= sp_d;
         tmr_q   <= tmr_d;
         acc_q   <= acc_d;
         carry_q <= carry_d;
         match_q <= match_d;
         stby_q  <= stby_d;
         rel_q   <= rel_d;
         bad_q   <= bad_d;
         o_int_reset <= irst_d;
      end
   end

   // Software owned words; start is refused while in standby.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         insn_q  <= 10'h000;
         opnd_q  <= 10'h000;
         page_q  <= 2'h0;
         div16_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= wr_en & (i_paddr == `BTME_A_EXEC) & i_pwdata[0]
                    & ~stby_q & (state_q == btme_pkg::BTME_IDLE)
                    & ~start_q;
         if (wr_en && i_paddr == `BTME_A_INSN) insn_q <= i_pwdata[9:0];
         if (wr_en && i_paddr == `BTME_A_OPND) opnd_q <= i_pwdata[9:0];
         if (wr_en && i_paddr == `BTME_A_CFG) begin
            page_q  <= i_pwdata[1:0];
            div16_q <= i_pwdata[2];
         end
      end
   end

   // Register pairs, one flop group per index; the op wins over APB.
   for (genvar n = 0; n < 16; n++) begin : g_bank
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            lo_bank_q[n] <= 4'h0;
            hi_bank_q[n] <= 4'h0;
         end else if (pair_wr && ridx == n) begin
            hi_bank_q[n] <= i_tbl_data[7:4];
            lo_bank_q[n] <= i_tbl_data[3:0];
         end else if (wr_en && is_lo && bidx == n) begin
            lo_bank_q[n] <= i_pwdata[3:0];
         end else if (wr_en && is_hi && bidx == n) begin
            hi_bank_q[n] <= i_pwdata[3:0];
         end
      end
   end

   // Timer: restarts on any load, expires after (value+1) prescaled ticks.
   wire tload = (tmr_d != tmr_q) | (go & (insn_q == `BTME_OP_LDTI
                | insn_q == `BTME_OP_LDTR | insn_q == `BTME_OP_WRT0
                | insn_q == `BTME_OP_WRT1));
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tcnt_q  <= 10'h000;
         pre_q   <= 4'h0;
         trun_q  <= 1'b0;
         tdone_q <= 1'b0;
      end else if (tload) begin
         tcnt_q  <= tmr_d;
         pre_q   <= 4'h0;
         trun_q  <= 1'b1;
         tdone_q <= 1'b0;
      end else if (trun_q && pre_q == pre_top) begin
         pre_q <= 4'h0;
         if (tcnt_q == 10'h000) begin
            trun_q  <= 1'b0;
            tdone_q <= 1'b1;
         end else begin
            tcnt_q <= tcnt_q - 10'h001;
         end
      end else if (trun_q) begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // Read mux; unmapped addresses answer with an error.
   logic [31:0] rdata_d;
   logic        rerr_d;
   always_comb begin
      rdata_d = 32'h0000_0000;
      rerr_d  = 1'b0;
      if (i_paddr == `BTME_A_INSN) begin
         rdata_d[9:0] = insn_q;
      end else if (i_paddr == `BTME_A_OPND) begin
         rdata_d[9:0] = opnd_q;
      end else if (i_paddr == `BTME_A_EXEC) begin
         rdata_d[6:0] = {bad_q, rel_q, stby_q,
                         start_q | (state_q != btme_pkg::BTME_IDLE)};
      end else if (i_paddr == `BTME_A_PC) begin
         rdata_d[9:0] = pc_q;
      end else if (i_paddr == `BTME_A_ACC) begin
         rdata_d[5:0] = {match_q, carry_q, acc_q};
      end else if (i_paddr == `BTME_A_TMR) begin
         rdata_d[21:0] = {trun_q, tdone_q, tcnt_q, tmr_q};
      end else if (i_paddr == `BTME_A_CFG) begin
         rdata_d[2:0] = {div16_q, page_q};
      end else if (i_paddr == `BTME_A_STK) begin
         rdata_d[9:0]         = asr_q;
         rdata_d[16+:SP_W]    = sp_q;
      end else if (is_lo && i_paddr[1:0] == 2'h0) begin
         rdata_d[3:0] = lo_bank_q[bidx];
      end else if (is_hi && i_paddr[1:0] == 2'h0) begin
         rdata_d[3:0] = hi_bank_q[bidx];
      end else begin
         rerr_d = 1'b1;
      end
   end

   // APB answer: one setup, one access with pready high.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= setup;
         o_prdata  <= (setup & ~i_pwrite) ? rdata_d : 32'h0000_0000;
         o_pslverr <= setup & rerr_d;
      end
   end

   // Table address follows page select over pair 0.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tbl_addr   <= 10'h000;
         o_standby    <= 1'b0;
         o_timer_done <= 1'b0;
      end else begin
         o_tbl_addr   <= {page_q, hi_bank_q[0], lo_bank_q[0]};
         o_standby    <= stby_d;
         o_timer_done <= tdone_q;
      end
   end

   property p_jmp;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_JMP |=> pc_q == $past(tgt);
   endproperty
   a_jmp: assert property (p_jmp) else $error("jmp target");

   property p_jc;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_JC |=>
         pc_q == ($past(carry_q) ? $past(tgt) : $past(pc_q) + 10'h002);
   endproperty
   a_jc: assert property (p_jc) else $error("jc next pc");

   property p_jnf;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_JNF |=>
         pc_q == (!$past(match_q) ? $past(tgt) : $past(pc_q) + 10'h002);
   endproperty
   a_jnf: assert property (p_jnf) else $error("jnf next pc");

   property p_call;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_CALL && !sp_full |=>
         asr_q == $past(pc_q) + 10'h002 ##1
         pc_q == $past(tgt) && !o_int_reset;
   endproperty
   a_call: assert property (p_call) else $error("call sequence");

   property p_ovf;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_CALL && sp_full |=>
         o_int_reset && pc_q == 10'h000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("no reset on overflow");

   property p_ret;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_RET |=> $past(sp_empty) ? o_int_reset
         : (pc_q == $past(asr_q) && sp_q == $past(sp_q) - SP_W'(1));
   endproperty
   a_ret: assert property (p_ret) else $error("ret result");

   property p_carry_if_all_ones;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_CARRY_IF_ALL_ONES |=>
         carry_q == ($past(acc_q) == `BTME_ALL_ONES) && $stable(acc_q);
   endproperty
   a_carry_if_all_ones: assert property (p_carry_if_all_ones) else $error("carry_if_all_ones carry");

   property p_idle;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_IDLE |=> pc_q == $past(pc_q) + 10'h001
         && $stable(carry_q) && $stable(match_q) && $stable(tmr_q);
   endproperty
   a_idle: assert property (p_idle) else $error("idle op changed state");

   property p_ldti;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      go && insn_q == `BTME_OP_LDTI |=> tmr_q == $past(tval) ##1 trun_q;
   endproperty
   a_ldti: assert property (p_ldti) else $error("timer load");
endmodule : btme_exec

// ### branch_timer_misc_exec_bench.sv
// Purpose: Self-checking bench for the branch, timer and misc unit.
// Assumes: Table data is a fixed scramble of the table address.
// Notes:   Ops are fed over APB; most results are read back over APB, table address, standby and timer done at the ports.
`timescale 1ns/1ps
`include "btme_defines.svh"
module branch_timer_misc_exec_bench;
   logic        clk, nrst, psel, pen, pwr, rdy, err, irst, stby, tdone;
   logic        s0, led, le;
   logic [11:0] pa;
   logic [31:0] pwd, prd, rv;
   logic [9:0]  ta, td;
   logic [7:0]  kb;
   logic [3:0]  ki;
   int          miscompares, compares, nres;
   logic [9:0]  bop [5] = '{`BTME_OP_JMP, `BTME_OP_JC, `BTME_OP_JNC,
                            `BTME_OP_JF, `BTME_OP_JNF};

   // Table contents; a rotate keeps every address bit visible in the data.
   function automatic logic [9:0] rom(logic [9:0] a);
      return {a[4:0], a[9:5]} ^ 10'h16C;
   endfunction : rom
   assign td = rom(ta);

   // Target and timer values packed as the operand words carry them.
   function automatic logic [9:0] scr(logic [9:0] a);
      return {a[9], a[7:4], a[8], a[3:0]};
   endfunction : scr
   function automatic logic [9:0] tmo(logic [9:0] t);
      return {t[1], t[9:6], t[0], t[5:2]};
   endfunction : tmo

   btme_exec i_btme_exec (
      .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy),
      .o_prdata(prd), .o_pslverr(err), .o_tbl_addr(ta), .i_tbl_data(td),
      .i_sense_input_zero(s0), .i_sense_led_pin(led),
      .i_key_bidir_lines(kb), .i_key_input_lines(ki), .o_int_reset(irst),
      .o_standby(stby), .o_timer_done(tdone)
   );

   // System clock, 4 ns period.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Count internal reset pulses; each stands for one cycle only.
   always @(posedge clk) begin
      if (irst === 1'b1) nres++;
   end

   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   // One APB transfer; an idle edge first so no signal is set twice.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      if (n >= 40) miscompares++;
      rv = prd;
      le = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   // Load an op and its operand, start it, wait until it is no longer busy.
   task automatic exec(logic [9:0] op, logic [9:0] od);
      int n;
      apb(1, `BTME_A_INSN, op);
      apb(1, `BTME_A_OPND, od);
      apb(1, `BTME_A_EXEC, 1);
      n = 0;
      do begin
         apb(0, `BTME_A_EXEC, 0);
         n++;
      end while (rv[0] !== 1'b0 && n < 20);
      if (rv[0] !== 1'b0) miscompares++;
   endtask : exec

   // Main sequence.
   initial begin
      logic [9:0] p, t, w;
      logic [3:0] m, h, n;
      logic [4:0] tk;
      logic [1:0] f;
      logic       x;
      int         k;
      {psel, pen, pwr, pa, pwd, s0, led, kb, ki} = '0;
      nrst = 1'b0;
      miscompares = 0;
      compares = 0;
      nres = 0;
      void'($urandom(32'hAA84084B));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      apb(0, `BTME_A_PC, 0);
      chk("pc_rst", rv, 0);
      apb(0, 12'hFFC, 0);
      chk("unmapped", 32'(le), 1);
      // Every branch kind with random flags; first targets are the ends.
      for (int i = 0; i < 40; i++) begin
         p = 10'($urandom);
         t = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
         f = 2'($urandom);
         tk = {~f[1], f[1], ~f[0], f[0], 1'b1};
         apb(1, `BTME_A_PC, p);
         apb(1, `BTME_A_ACC, {f, 4'hA});
         exec(bop[i % 5], scr(t));
         apb(0, `BTME_A_PC, 0);
         chk("br_pc", rv, tk[i % 5] ? t : 10'(p + 2));
         apb(0, `BTME_A_ACC, 0);
         chk("br_flags", rv, {f, 4'hA});
      end
      // All sixteen accumulator values, carry preset to the wrong side.
      for (int a = 0; a < 16; a++) begin
         f = {a[0], a != 15};
         apb(1, `BTME_A_ACC, {f, 4'(a)});
         exec(`BTME_OP_CARRY_IF_ALL_ONES, 0);
         apb(0, `BTME_A_ACC, 0);
         chk("carry_if_all_ones", rv, {f[1], a == 15, 4'(a)});
      end
      // The idle op wraps the counter from the top address.
      apb(1, `BTME_A_PC, 10'h3FF);
      exec(`BTME_OP_IDLE, 0);
      apb(0, `BTME_A_PC, 0);
      chk("idle", rv, 0);
      // An undecoded word must raise the unknown-opcode flag.
      exec(10'h2AA, 0);
      apb(0, `BTME_A_EXEC, 0);
      chk("unknown", rv[6], 1);
      // Table reads into pairs 1 and F and six random pairs, then the timer.
      for (int i = 0; i < 8; i++) begin
         w = 10'($urandom);
         n = (i == 0) ? 4'h1 : (i == 1) ? 4'hF : 4'($urandom % 15 + 1);
         apb(1, `BTME_A_CFG, w[9:8]);
         apb(1, 12'h080, w[7:4]);
         apb(1, 12'h040, w[3:0]);
         repeat (2) @(posedge clk);
         chk("tbl_addr", ta, w);
         t = rom(w);
         exec({`BTME_PF_LDPAIR, n}, 0);
         apb(0, 12'h080 + {n, 2'b00}, 0);
         chk("pair_hi", rv, t[7:4]);
         apb(0, 12'h040 + {n, 2'b00}, 0);
         chk("pair_lo", rv, t[3:0]);
         exec(`BTME_OP_LDTR, 0);
         apb(0, `BTME_A_TMR, 0);
         chk("tmr_tbl", rv[9:0], {t[8:5], t[3:0], t[9], t[4]});
      end
      // Status tests with a long timer running so its status stays low.
      exec(`BTME_OP_LDTI, tmo(10'h3FF));
      for (int i = 0; i < 24; i++) begin
         m = 4'($urandom);
         h = 4'($urandom);
         kb <= ($urandom % 3 == 0) ? 8'($urandom) : 8'h00;
         ki <= ($urandom % 3 == 0) ? 4'($urandom) : 4'h0;
         s0 <= 1'($urandom);
         led <= 1'($urandom);
         @(posedge clk);
         x = |(m & {1'b0, |{kb, ki}, led, s0});
         apb(1, `BTME_A_ACC, {~x, 5'h13});
         if (i % 2 == 1) begin
            exec(`BTME_OP_STTSI, m);
         end else begin
            apb(1, 12'h040 + {h, 2'b00}, m);
            exec({`BTME_PF_STTSR, h}, 0);
         end
         apb(0, `BTME_A_ACC, 0);
         chk("match", rv, {x, 5'h13});
      end
      // Immediate load, nibble reads, then nibble writes over it.
      for (int i = 0; i < 8; i++) begin
         t = 10'($urandom);
         m = 4'($urandom);
         h = 4'($urandom);
         exec(`BTME_OP_LDTI, tmo(t));
         apb(0, `BTME_A_TMR, 0);
         chk("tmr_imm", rv[9:0], t);
         apb(1, `BTME_A_ACC, 32'h3F);
         exec(`BTME_OP_RDT1, 0);
         apb(0, `BTME_A_ACC, 0);
         chk("rd_top", rv, {2'b10, t[9:6]});
         exec(`BTME_OP_RDT0, 0);
         apb(0, `BTME_A_ACC, 0);
         chk("rd_mid", rv, {2'b10, t[5:2]});
         apb(1, `BTME_A_ACC, m);
         exec(`BTME_OP_WRT1, 0);
         apb(1, `BTME_A_ACC, h);
         exec(`BTME_OP_WRT0, 0);
         apb(0, `BTME_A_TMR, 0);
         chk("tmr_nib", rv[9:0], {m, h, 2'b00});
      end
      // Interval for value 3 at both dividers, counted from the start edge.
      for (int d = 0; d < 2; d++) begin
         apb(1, `BTME_A_CFG, 32'(d) << 2);
         apb(1, `BTME_A_INSN, `BTME_OP_LDTI);
         apb(1, `BTME_A_OPND, tmo(10'h003));
         apb(1, `BTME_A_EXEC, 1);
         repeat (3) @(posedge clk);
         k = 3;
         while (tdone !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
         end
         chk("span", k, 32 * (d + 1) + 3);
      end
      // The expired timer alone must satisfy a timer-only mask.
      apb(1, `BTME_A_ACC, 0);
      exec(`BTME_OP_STTSI, 4'h8);
      apb(0, `BTME_A_ACC, 0);
      chk("match_tmr", rv, 32'h20);
      // Invoke and exit, then an exit underflow and an invoke overflow.
      for (int i = 0; i < 2; i++) begin
         p = (i == 0) ? 10'h3FE : 10'($urandom);
         t = 10'($urandom);
         apb(1, `BTME_A_PC, p);
         exec(`BTME_OP_CALL, scr(t));
         apb(0, `BTME_A_PC, 0);
         chk("call_pc", rv, t);
         apb(0, `BTME_A_STK, 0);
         chk("call_stk", rv, {15'h0, 1'b1, 6'h00, 10'(p + 2)});
         exec(`BTME_OP_RET, 0);
         apb(0, `BTME_A_PC, 0);
         chk("ret_pc", rv, 10'(p + 2));
         if (i == 1) exec(`BTME_OP_CALL, scr(t));
         apb(1, `BTME_A_ACC, 32'h3F);
         k = nres;
         exec(i ? `BTME_OP_CALL : `BTME_OP_RET, scr(t));
         chk("flt_pulse", nres - k, 1);
         apb(0, `BTME_A_PC, 0);
         chk("flt_pc", rv, 0);
         apb(0, `BTME_A_ACC, 0);
         chk("flt_flags", rv[5:4], 0);
      end
      // Standby keeps its release mask and holds off new ops until woken.
      for (int i = 0; i < 2; i++) begin
         m = i ? 4'h5 : 4'hA;
         apb(1, `BTME_A_PC, 10'h100);
         exec(`BTME_OP_HALT, m);
         apb(0, `BTME_A_EXEC, 0);
         chk("stby", {rv[5:1], stby}, {m, 2'b11});
         exec(`BTME_OP_IDLE, 0);
         apb(0, `BTME_A_PC, 0);
         chk("stby_pc", rv, 10'h102);
         apb(1, `BTME_A_EXEC, 2);
         repeat (2) @(posedge clk);
         chk("wake", 32'(stby), 0);
      end
      stop_test();
   end

   // Cut a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule : branch_timer_misc_exec_bench
